// ---- logic/uicr_pkg.sv ----
// Package: offsets, field positions and reset values of the interrupt-clear and ident registers.
// Assumes a 32-bit word register port with byte offsets.
package uicr_pkg;
   localparam logic [11:0] OFF_INTERRUPT_CLEAR  = 12'h044;
   localparam logic [11:0] OFF_RAW_STATUS       = 12'h03c;
   localparam logic [11:0] OFF_IRQ_MASK         = 12'h038;
   localparam logic [11:0] OFF_MASKED_STATUS    = 12'h040;
   localparam logic [11:0] OFF_PERIPH_IDENT4    = 12'hfd0;
   localparam logic [11:0] OFF_PERIPH_IDENT5    = 12'hfd4;
   localparam logic [11:0] OFF_PERIPH_IDENT6    = 12'hfd8;
   // Field positions inside the clear, raw, mask and masked words
   localparam int          POS_FRAMING_ERR      = 7;
   localparam int          POS_RX_TIMEOUT       = 6;
   localparam int          POS_TX               = 5;
   localparam int          POS_RX               = 4;
   localparam int          POS_SRC_LO           = 4;
   localparam int          NUM_SRC              = 4;
   localparam logic [3:0]  RESERVED_LO_RESET    = 4'h0;
   localparam logic [3:0]  SRC_RESET            = 4'h0;
   localparam logic [31:0] RDATA_RESET          = 32'h0000_0000;
   // Ident bytes: arbitrary neutral values
   localparam logic [7:0]  IDENT_BYTE4          = 8'ha5;
   localparam logic [7:0]  IDENT_BYTE5          = 8'h5a;
   localparam logic [7:0]  IDENT_BYTE6          = 8'hc3;
   typedef enum logic [1:0] {
      UICR_IDLE_type_S  = 2'b00,
      UICR_READ_type_S  = 2'b01
   } uicr_bus_state_type;
endpackage : uicr_pkg

// ---- logic/uicr_ident_rom.sv ----
// Constant ident word table with registered read data.
// Assumes sel is one-hot or zero, from logic on the same clock.
`timescale 1ns/1ps
module uicr_ident_rom (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Lookup
   input  wire logic [2:0]  sel,
   output      logic [31:0] word
);
   wire logic [31:0] next_word;

   // Top 24 bits are always zero
   assign next_word = sel[0] ? {24'h00_0000, uicr_pkg::IDENT_BYTE4} :
                      sel[1] ? {24'h00_0000, uicr_pkg::IDENT_BYTE5} :
                      sel[2] ? {24'h00_0000, uicr_pkg::IDENT_BYTE6} :
                               uicr_pkg::RDATA_RESET;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) word <= uicr_pkg::RDATA_RESET;
      else word <= next_word;
   end
endmodule : uicr_ident_rom

// ---- logic/uicr_src_flag.sv ----
// One sticky interrupt source: set by engine pulse, cleared by write-one.
// Assumes set pulse comes from logic on core_clk.
`timescale 1ns/1ps
module uicr_src_flag (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic arst_n,
   // Control
   input  wire logic set_pulse,
   input  wire logic clear_pulse,
   output      logic flag
);
   wire logic next_flag;

   // Set wins over a clear in the same cycle so no event is lost
   assign next_flag = set_pulse | (flag & ~clear_pulse);

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) flag <= 1'b0;
      else flag <= next_flag;
   end
endmodule : uicr_src_flag

// ---- logic/uicr_regs.sv ----
// Interrupt-clear register, raw/mask/masked status and ident registers of the serial port.
// Assumes single-cycle strobes on core_clk; engine event pulses are on core_clk.
//
// What this block does
// - Writing 1 to bit 7 clears the framing-error interrupt; 0 does nothing.
// - Writing 1 to bit 6 clears the receive time-out interrupt; 0 does nothing.
// - Writing 1 to bit 5 clears the transmit interrupt; 0 does nothing.
// - Writing 1 to bit 4 clears the receive interrupt; 0 does nothing.
// - Bits 3:0 of the clear register are reserved, read zero, ignore writes.
// - Ident registers are constants, read-only, bits 31:8 read zero.
// - Ident register at 0xfd0 gives ident byte four in low eight bits.
// - Ident register at 0xfd4 gives ident byte five in low eight bits.
// - Ident register at 0xfd8 gives ident byte six in low eight bits.
// - A clear removes the raw flag and the masked output of that source.
`timescale 1ns/1ps
module uicr_regs (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // Register port
   input  wire logic [11:0] addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output      logic [31:0] rdata,
   // Engine event pulses: framing, rx timeout, tx, rx
   input  wire logic        framing_err_evt,
   input  wire logic        rx_timeout_evt,
   input  wire logic        tx_evt,
   input  wire logic        rx_evt,
   // Flags toward the engine
   output      logic [3:0]  raw_flags,
   output      logic [3:0]  masked_flags
);
   logic        [3:0]  raw;
   logic        [3:0]  mask;
   logic        [31:0] reg_word;
   logic        [31:0] rom_word;
   logic               rom_hit;
   wire logic   [3:0]  set_vec;
   wire logic   [3:0]  clr_vec;
   wire logic   [2:0]  ident_sel;
   wire logic          hit_clear;
   wire logic          hit_mask;
   wire logic          hit_raw;
   wire logic          hit_masked;
   wire logic   [31:0] next_reg_word;
   wire logic   [3:0]  next_mask;
   wire logic          hit_ident4;
   wire logic          hit_ident5;
   wire logic          hit_ident6;
   wire logic   [31:0] next_id_word;
   wire logic   [31:0] next_rdata;
   wire logic   [3:0]  next_masked;

   function automatic logic [31:0] place_src(input logic [3:0] v);
      place_src = {24'h00_0000, v, uicr_pkg::RESERVED_LO_RESET};
   endfunction : place_src

   assign hit_clear  = addr == uicr_pkg::OFF_INTERRUPT_CLEAR;
   assign hit_mask   = addr == uicr_pkg::OFF_IRQ_MASK;
   assign hit_raw    = addr == uicr_pkg::OFF_RAW_STATUS;
   assign hit_masked = addr == uicr_pkg::OFF_MASKED_STATUS;
   assign hit_ident4 = addr == uicr_pkg::OFF_PERIPH_IDENT4;
   assign hit_ident5 = addr == uicr_pkg::OFF_PERIPH_IDENT5;
   assign hit_ident6 = addr == uicr_pkg::OFF_PERIPH_IDENT6;
   assign ident_sel  = rd_stb ? {hit_ident6, hit_ident5, hit_ident4} : 3'h0;

   assign set_vec = {framing_err_evt, rx_timeout_evt, tx_evt, rx_evt};
   // Only bits 7:4 act; reserved bits 3:0 and bits above are dropped
   assign clr_vec = (wr_stb && hit_clear) ?
                    wdata[uicr_pkg::POS_SRC_LO +: uicr_pkg::NUM_SRC] : 4'h0;

   genvar gi;
   generate
      for (gi = 0; gi < uicr_pkg::NUM_SRC; gi++) begin : g_src
         uicr_src_flag u_flag (
            .core_clk    (core_clk),
            .arst_n      (arst_n),
            .set_pulse   (set_vec[gi]),
            .clear_pulse (clr_vec[gi]),
            .flag        (raw[gi])
         );
      end
   endgenerate

   // Writes to ident offsets match no writable register and vanish
   assign next_mask = (wr_stb && hit_mask) ?
                      wdata[uicr_pkg::POS_SRC_LO +: uicr_pkg::NUM_SRC] : mask;

   // Clear register reads zero: write-only clear bits, reserved low bits
   assign next_reg_word = !rd_stb   ? uicr_pkg::RDATA_RESET :
                          hit_raw    ? place_src(raw) :
                          hit_mask   ? place_src(mask) :
                          hit_masked ? place_src(raw & mask) :
                                       uicr_pkg::RDATA_RESET;

   uicr_ident_rom u_rom (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .sel      (ident_sel),
      .word     (rom_word)
   );

   // Ident word computed in parallel so rdata is one cycle after the strobe
   assign next_id_word = ident_sel[0] ? {24'h00_0000, uicr_pkg::IDENT_BYTE4} :
                         ident_sel[1] ? {24'h00_0000, uicr_pkg::IDENT_BYTE5} :
                         ident_sel[2] ? {24'h00_0000, uicr_pkg::IDENT_BYTE6} :
                                        uicr_pkg::RDATA_RESET;
   assign next_rdata   = next_reg_word | next_id_word;
   assign next_masked  = raw & mask;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mask <= uicr_pkg::SRC_RESET;
      end else begin
         mask <= next_mask;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_word <= uicr_pkg::RDATA_RESET;
      end else begin
         reg_word <= next_reg_word;
      end
   end

   // Table copy is a cross-check only; the table and the mux path both give the word one cycle after the strobe
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rom_hit <= 1'b0;
      end else begin
         rom_hit <= |ident_sel;
      end
   end

   // Flags straight from flip-flops
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         raw_flags <= uicr_pkg::SRC_RESET;
      end else begin
         raw_flags <= raw;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         masked_flags <= uicr_pkg::SRC_RESET;
      end else begin
         masked_flags <= next_masked;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= uicr_pkg::RDATA_RESET;
      end else begin
         rdata <= next_rdata;
      end
   end

   // Assertions
   property p_clear_fe;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && hit_clear && wdata[uicr_pkg::POS_FRAMING_ERR] && !framing_err_evt) |=> !raw[3];
   endproperty
   a_clear_fe: assert property (p_clear_fe) else $error("framing flag not cleared");

   property p_clear_rt;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && hit_clear && wdata[uicr_pkg::POS_RX_TIMEOUT] && !rx_timeout_evt) |=> ##1 !raw_flags[2];
   endproperty
   a_clear_rt: assert property (p_clear_rt) else $error("timeout flag not cleared");

   property p_clear_tx;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && hit_clear && wdata[uicr_pkg::POS_TX] && !tx_evt) |=> !raw[1];
   endproperty
   a_clear_tx: assert property (p_clear_tx) else $error("tx flag not cleared");

   property p_clear_rx;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && hit_clear && wdata[uicr_pkg::POS_RX] && !rx_evt) |=> !raw[0];
   endproperty
   a_clear_rx: assert property (p_clear_rx) else $error("rx flag not cleared");

   property p_zero_keeps;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && hit_clear && wdata[7:4] == 4'h0 && set_vec == 4'h0) |=> raw == $past(raw);
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed a flag");

   property p_ident_hi;
      @(posedge core_clk) disable iff (!arst_n)
      (rd_stb && ident_sel != 3'h0) |=> rdata[31:8] == 24'h00_0000;
   endproperty
   a_ident_hi: assert property (p_ident_hi) else $error("ident high bits not zero");

   property p_ident4;
      @(posedge core_clk) disable iff (!arst_n)
      (rd_stb && addr == uicr_pkg::OFF_PERIPH_IDENT4) |=> rdata[7:0] == uicr_pkg::IDENT_BYTE4;
   endproperty
   a_ident4: assert property (p_ident4) else $error("ident byte four wrong");

   property p_ident5;
      @(posedge core_clk) disable iff (!arst_n)
      (rd_stb && addr == uicr_pkg::OFF_PERIPH_IDENT5) |=> rdata[7:0] == uicr_pkg::IDENT_BYTE5;
   endproperty
   a_ident5: assert property (p_ident5) else $error("ident byte five wrong");

   property p_ident6;
      @(posedge core_clk) disable iff (!arst_n)
      (rd_stb && addr == uicr_pkg::OFF_PERIPH_IDENT6) |=> rdata[7:0] == uicr_pkg::IDENT_BYTE6;
   endproperty
   a_ident6: assert property (p_ident6) else $error("ident byte six wrong");

   property p_masked_follows;
      @(posedge core_clk) disable iff (!arst_n)
      ##1 1'b1 |-> masked_flags == ($past(raw) & $past(mask));
   endproperty
   a_masked_follows: assert property (p_masked_follows) else $error("masked flags wrong");

   property p_ident_write;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && addr[11:4] == 8'hfd) |=> mask == $past(mask);
   endproperty
   a_ident_write: assert property (p_ident_write) else $error("ident write had effect");

   property p_fe_zero_keeps;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && hit_clear && !wdata[uicr_pkg::POS_FRAMING_ERR] && !framing_err_evt) |=> raw[3] == $past(raw[3]);
   endproperty
   a_fe_zero_keeps: assert property (p_fe_zero_keeps) else $error("zero write changed framing flag");

   property p_rt_zero_keeps;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && hit_clear && !wdata[uicr_pkg::POS_RX_TIMEOUT] && !rx_timeout_evt) |=> raw[2] == $past(raw[2]);
   endproperty
   a_rt_zero_keeps: assert property (p_rt_zero_keeps) else $error("zero write changed timeout flag");

   property p_tx_zero_keeps;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && hit_clear && !wdata[uicr_pkg::POS_TX] && !tx_evt) |=> raw[1] == $past(raw[1]);
   endproperty
   a_tx_zero_keeps: assert property (p_tx_zero_keeps) else $error("zero write changed tx flag");

   property p_rx_zero_keeps;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && hit_clear && !wdata[uicr_pkg::POS_RX] && !rx_evt) |=> raw[0] == $past(raw[0]);
   endproperty
   a_rx_zero_keeps: assert property (p_rx_zero_keeps) else $error("zero write changed rx flag");

   property p_reserved_ignored;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && hit_clear && wdata[3:0] != 4'h0 && wdata[7:4] == 4'h0 && set_vec == 4'h0) |=> raw == $past(raw);
   endproperty
   a_reserved_ignored: assert property (p_reserved_ignored) else $error("reserved write changed a flag");

   property p_set_wins;
      @(posedge core_clk) disable iff (!arst_n)
      (set_vec != 4'h0) |=> (raw & $past(set_vec)) == $past(set_vec);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost against a clear");

   property p_raw_port;
      @(posedge core_clk) disable iff (!arst_n)
      ##1 1'b1 |-> raw_flags == $past(raw);
   endproperty
   a_raw_port: assert property (p_raw_port) else $error("raw flag port wrong");

   property p_raw_clear;
      @(posedge core_clk) disable iff (!arst_n)
      (clr_vec != 4'h0 && (clr_vec & set_vec) == 4'h0) |=> ##1 (raw_flags & $past(clr_vec, 2)) == 4'h0;
   endproperty
   a_raw_clear: assert property (p_raw_clear) else $error("raw flag port not cleared");

   property p_masked_clear;
      @(posedge core_clk) disable iff (!arst_n)
      (clr_vec != 4'h0 && (clr_vec & set_vec) == 4'h0) |=> ##1 (masked_flags & $past(clr_vec, 2)) == 4'h0;
   endproperty
   a_masked_clear: assert property (p_masked_clear) else $error("masked flag port not cleared");

   property p_masked_gated;
      @(posedge core_clk) disable iff (!arst_n)
      ##1 1'b1 |-> (masked_flags & ~$past(mask)) == 4'h0;
   endproperty
   a_masked_gated: assert property (p_masked_gated) else $error("disabled source shows masked");

   property p_mask_write;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && hit_mask) |=> mask == $past(wdata[uicr_pkg::POS_SRC_LO +: uicr_pkg::NUM_SRC]);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("enable write not taken");

   property p_mask_hold;
      @(posedge core_clk) disable iff (!arst_n)
      !(wr_stb && hit_mask) |=> mask == $past(mask);
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("enable changed without write");

   property p_ident_write_raw;
      @(posedge core_clk) disable iff (!arst_n)
      (wr_stb && (hit_ident4 || hit_ident5 || hit_ident6) && set_vec == 4'h0) |=> raw == $past(raw);
   endproperty
   a_ident_write_raw: assert property (p_ident_write_raw) else $error("ident write changed a flag");

   property p_rom_hit_follows;
      @(posedge core_clk) disable iff (!arst_n)
      ##1 1'b1 |-> rom_hit == $past(rd_stb && (hit_ident4 || hit_ident5 || hit_ident6));
   endproperty
   a_rom_hit_follows: assert property (p_rom_hit_follows) else $error("ident read flag wrong");

   property p_rom_agrees;
      @(posedge core_clk) disable iff (!arst_n)
      rom_hit |-> rdata == rom_word;
   endproperty
   a_rom_agrees: assert property (p_rom_agrees) else $error("ident read differs from table");

   property p_reg_agrees;
      @(posedge core_clk) disable iff (!arst_n)
      !rom_hit |-> rdata == reg_word;
   endproperty
   a_reg_agrees: assert property (p_reg_agrees) else $error("register read differs");

   property p_clear_reads_zero;
      @(posedge core_clk) disable iff (!arst_n)
      (rd_stb && hit_clear) |=> rdata == uicr_pkg::RDATA_RESET;
   endproperty
   a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register read not zero");

   property p_unmapped_zero;
      @(posedge core_clk) disable iff (!arst_n)
      (rd_stb && !(hit_raw || hit_mask || hit_masked || hit_ident4 || hit_ident5 || hit_ident6))
         |=> rdata == uicr_pkg::RDATA_RESET;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

   property p_rdata_idle;
      @(posedge core_clk) disable iff (!arst_n)
      !rd_stb |=> rdata == uicr_pkg::RDATA_RESET;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule : uicr_regs

// ---- tb/uicr_regs_tb_top.sv ----
// Self-checking bench for the interrupt-clear and ident register block.
// Assumes one-cycle read latency and flag ports one cycle behind flag state.
`timescale 1ns/1ps
module uicr_regs_tb_top;
   logic        core_clk;
   logic        arst_n;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic        wr_stb;
   logic        rd_stb;
   logic [31:0] rdata;
   logic [3:0]  evt;
   logic [3:0]  raw_flags;
   logic [3:0]  masked_flags;
   logic [3:0]  model_flags;
   logic [3:0]  model_mask;
   logic [31:0] rnd;
   integer      seed;
   integer      miscompares;
   integer      num_checks;
   integer      i;

   uicr_regs dut_u (
      .core_clk        (core_clk),
      .arst_n          (arst_n),
      .addr            (addr),
      .wdata           (wdata),
      .wr_stb          (wr_stb),
      .rd_stb          (rd_stb),
      .rdata           (rdata),
      .framing_err_evt (evt[3]),
      .rx_timeout_evt  (evt[2]),
      .tx_evt          (evt[1]),
      .rx_evt          (evt[0]),
      .raw_flags       (raw_flags),
      .masked_flags    (masked_flags)
   );

   always #4 core_clk = ~core_clk;

   // Status words carry the four sources in bits 7:4
   function automatic logic [31:0] f_word(input logic [3:0] f);
      return {24'h0, f, 4'h0};
   endfunction : f_word

   // Only ones in bits 7:4 clear; zeros and reserved bits do nothing
   function automatic logic [3:0] f_clear(input logic [3:0] f, input logic [31:0] d);
      return f & ~d[7:4];
   endfunction : f_clear

   function automatic logic [11:0] f_id_addr(input integer k);
      case (k)
         0: return uicr_pkg::OFF_PERIPH_IDENT4;
         1: return uicr_pkg::OFF_PERIPH_IDENT5;
         default: return uicr_pkg::OFF_PERIPH_IDENT6;
      endcase
   endfunction : f_id_addr

   function automatic logic [7:0] f_id_byte(input integer k);
      case (k)
         0: return uicr_pkg::IDENT_BYTE4;
         1: return uicr_pkg::IDENT_BYTE5;
         default: return uicr_pkg::IDENT_BYTE6;
      endcase
   endfunction : f_id_byte

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask : wr

   // Data valid only in the cycle after the strobe, zero afterwards
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1;
      check(rdata, exp);
      @(posedge core_clk);
      #1;
      check(rdata, 32'h0);
   endtask : rd_chk

   task automatic pulse(input logic [3:0] v);
      @(posedge core_clk);
      evt <= v;
      @(posedge core_clk);
      evt <= 4'h0;
      model_flags = model_flags | v;
   endtask : pulse

   // Two edges: flag update, then the registered port copy
   task automatic check_all;
      repeat (2) @(posedge core_clk);
      #1;
      check({28'h0, raw_flags}, {28'h0, model_flags});
      check({28'h0, masked_flags}, {28'h0, model_flags & model_mask});
      rd_chk(uicr_pkg::OFF_RAW_STATUS, f_word(model_flags));
      rd_chk(uicr_pkg::OFF_MASKED_STATUS, f_word(model_flags & model_mask));
   endtask : check_all

   task automatic wrap_up;
      $display("checks=%0d miscompares=%0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   // Hang guard; the run itself takes under a thousand cycles
   initial begin
      #200000;
      miscompares = miscompares + 1;
      wrap_up();
   end

   initial begin
      core_clk = 1'b0;
      arst_n = 1'b0;
      addr = 12'h000;
      wdata = 32'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      evt = 4'h0;
      seed = 32'he63b;
      miscompares = 0;
      num_checks = 0;
      model_flags = 4'h0;
      model_mask = 4'h0;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      rd_chk(uicr_pkg::OFF_INTERRUPT_CLEAR, 32'h0);
      for (i = 0; i < 3; i = i + 1) begin
         rd_chk(f_id_addr(i), {24'h0, f_id_byte(i)});
         wr(f_id_addr(i), $random(seed));
         rd_chk(f_id_addr(i), {24'h0, f_id_byte(i)});
      end
      rd_chk(12'h100, 32'h0);
      wr(uicr_pkg::OFF_IRQ_MASK, 32'h0000_00f0);
      model_mask = 4'hf;
      // Each source alone: zeros and reserved ones first, then its own bit
      for (i = 0; i < 4; i = i + 1) begin
         pulse(4'hf);
         wr(uicr_pkg::OFF_INTERRUPT_CLEAR, 32'hffff_ff0f);
         check_all();
         wr(uicr_pkg::OFF_INTERRUPT_CLEAR, 32'h0000_0010 << i);
         model_flags = f_clear(model_flags, 32'h0000_0010 << i);
         check_all();
      end
      for (i = 0; i < 30; i = i + 1) begin
         rnd = $random(seed);
         pulse(rnd[3:0]);
         // Reserved bits written back as read, which is zero
         wr(uicr_pkg::OFF_IRQ_MASK, {24'h0, rnd[7:4], 4'h0});
         model_mask = rnd[7:4];
         rd_chk(uicr_pkg::OFF_IRQ_MASK, f_word(model_mask));
         rnd = $random(seed);
         wr(uicr_pkg::OFF_INTERRUPT_CLEAR, rnd);
         model_flags = f_clear(model_flags, rnd);
         check_all();
         rd_chk(uicr_pkg::OFF_INTERRUPT_CLEAR, 32'h0);
      end
      // Second reset in mid-run drops flags and enables
      pulse(4'hf);
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      model_flags = 4'h0;
      model_mask = 4'h0;
      check_all();
      rd_chk(uicr_pkg::OFF_IRQ_MASK, 32'h0);
      wrap_up();
   end
endmodule : uicr_regs_tb_top
